// file: core/param_store_regs.vh
// constants for the parameter store and maintenance command block
`ifndef PARAM_STORE_REGS_VH
`define PARAM_STORE_REGS_VH
`define PS_WORD_W 32
`define PS_IDX_W 4
`define PS_DEPTH 16
`define PS_ID_W 16
`define PS_CMD_ALARM_RST 16'h00c0
`define PS_CMD_CLR_ALM_HIST 16'h00c2
`define PS_CMD_CLR_COM_HIST 16'h00c4
`define PS_CMD_POS_PRESET 16'h00c5
`define PS_CMD_CONFIG 16'h00c6
`define PS_CMD_INIT_PART 16'h00c7
`define PS_CMD_NV_LOAD 16'h00c8
`define PS_CMD_NV_SAVE 16'h00c9
`define PS_CMD_INIT_ALL 16'h00ca
`define PS_CMD_CLR_TORQUE_OFF 16'h00d0
`define PS_CMD_ZERO_PRESET 16'h00d1
`define PS_CMD_CLR_ZERO_PRESET 16'h00d2
`define PS_CMD_HIST_SEL 16'h00d5
`define PS_HIST_SEL_MAX 32'h0000000a
`define PS_CLASS_A 2'h0
`define PS_CLASS_B 2'h1
`define PS_CLASS_C 2'h2
`define PS_CLASS_D 2'h3
`define PS_COMM_FIRST 4'hc
`define PS_INIT_VAL 32'h00000000
`endif

// file: core/param_slot.v
// one parameter slot: working copy, stored copy and applied value
`timescale 1ns/1ps
`default_nettype none
`include "param_store_regs.vh"
module param_slot #(
	parameter [1:0] UPD_CLASS = 2'h0,
	parameter IS_COMM = 0
) (
	// clock and reset
	input wire clk_sys,
	input wire resetn,
	// operations
	input wire wr_en,
	input wire [31:0] wr_data,
	input wire boot,
	input wire nv_save,
	input wire nv_load,
	input wire init_part,
	input wire init_all,
	input wire config_cmd,
	input wire motion_stopped,
	// results
	output wire [31:0] work_val,
	output wire [31:0] nv_val,
	output wire [31:0] applied_val
);
	reg [31:0] work_q;
	reg [31:0] nv_q;
	reg [31:0] app_q;
	reg pend_q;
	wire init_hit;
	wire reload;
	assign init_hit = init_all | (init_part & (IS_COMM == 0)); // RULE14 RULE15
	assign reload = boot | nv_load;
	// stored copy has no reset: it models storage that survives power loss
	always @(posedge clk_sys)
	begin
		if (nv_save)
			nv_q <= work_q; // RULE5 RULE2
	end
	always @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			work_q <= `PS_INIT_VAL;
			app_q <= `PS_INIT_VAL;
			pend_q <= 1'b0;
		end
		else if (reload)
		begin
			work_q <= nv_q; // RULE3 RULE13
			if (boot)
			begin
				app_q <= nv_q; // RULE3 RULE9
				pend_q <= 1'b0;
			end
			else
				pend_q <= 1'b1;
		end
		else if (init_hit)
		begin
			work_q <= `PS_INIT_VAL;
			pend_q <= 1'b1;
		end
		else if (wr_en)
		begin
			work_q <= wr_data; // RULE4 RULE1
			if (UPD_CLASS == `PS_CLASS_A)
				app_q <= wr_data; // RULE6
			else
				pend_q <= 1'b1;
		end
		else if (pend_q)
		begin
			if (UPD_CLASS == `PS_CLASS_A)
			begin
				app_q <= work_q;
				pend_q <= 1'b0;
			end
			else if (UPD_CLASS == `PS_CLASS_B && motion_stopped)
			begin
				app_q <= work_q; // RULE7
				pend_q <= 1'b0;
			end
			else if (UPD_CLASS == `PS_CLASS_C && config_cmd)
			begin
				app_q <= work_q; // RULE8
				pend_q <= 1'b0;
			end
		end
	end
	assign work_val = work_q;
	assign nv_val = nv_q;
	assign applied_val = app_q;
endmodule
`default_nettype wire

// file: core/param_store_maint.v
// parameter store with maintenance command decoder
// How it works
// RULE1: every parameter is a 32-bit word
// RULE2: volatile working copy plus nonvolatile stored copy
// RULE3: power-up loads stored copy, then applies it
// RULE4: cyclic writes touch only working copy
// RULE5: save command copies working copy to storage
// RULE6: class A applies at once on write
// RULE7: class B applies once motion has stopped
// RULE8: class C applies on configuration or power-up
// RULE9: class D applies only at power-up
// RULE10: scanner saves power-cycle parameters before power-off
// RULE11: scanner limits save count, storage wears out
// RULE12: scanner avoids rapid repeated memory commands
// RULE13: load command reloads working copy from storage
// RULE14: partial init keeps communication parameters
// RULE15: full init resets all parameters
// RULE16: 192/194/196 reset alarm, clear histories
// RULE17: history selector takes 1..10, 0 none
// RULE18: one execution per command write, value ignored; PS_CMD_HIST_SEL uses its value as the selector
`timescale 1ns/1ps
`default_nettype none
`include "param_store_regs.vh"
module param_store_maint (
	// clock and reset
	input wire clk_sys,
	input wire resetn,
	// parameter write from the scanner
	input wire wr_req,
	input wire [15:0] wr_id,
	input wire [31:0] wr_data,
	// drive state
	input wire motion_stopped,
	// parameter readback
	input wire [3:0] rd_idx,
	output reg [31:0] rd_work,
	output reg [31:0] rd_applied,
	output reg [31:0] rd_nv,
	// command pulses
	output reg alarm_reset,
	output reg alarm_hist_clear,
	output reg comm_hist_clear,
	output reg position_preset,
	output reg torque_off_latch_clear,
	output reg encoder_zero_preset_command,
	output reg encoder_zero_preset_clear,
	output reg busy,
	// alarm history selector
	output reg [3:0] hist_sel
);
	reg boot_q;
	reg cmd_q;
	reg data_q;
	reg [15:0] id_q;
	reg [31:0] dat_q;
	wire [31:0] work_v [0:15];
	wire [31:0] app_v [0:15];
	wire [31:0] nv_v [0:15];
	wire is_cmd;
	wire c_save;
	wire c_load;
	wire c_ipart;
	wire c_iall;
	wire c_cfg;
	// ids 192..255 are commands, 0..15 are parameter slots
	assign is_cmd = (wr_id[15:6] == 10'h003);
	// a write request is a single-cycle strobe; each one fires once
	always @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			boot_q <= 1'b1;
			cmd_q <= 1'b0;
			data_q <= 1'b0;
			id_q <= 16'h0000;
			dat_q <= 32'h00000000;
		end
		else
		begin
			boot_q <= 1'b0;
			cmd_q <= wr_req & is_cmd; // RULE18
			data_q <= wr_req & (wr_id[15:4] == 12'h000);
			id_q <= wr_id;
			dat_q <= wr_data;
		end
	end
	assign c_save = cmd_q & (id_q == `PS_CMD_NV_SAVE);
	assign c_load = cmd_q & (id_q == `PS_CMD_NV_LOAD);
	assign c_ipart = cmd_q & (id_q == `PS_CMD_INIT_PART);
	assign c_iall = cmd_q & (id_q == `PS_CMD_INIT_ALL);
	assign c_cfg = cmd_q & (id_q == `PS_CMD_CONFIG);
	// slot classes cycle A,B,C,D; top four slots hold comm settings
	genvar g;
	generate
		for (g = 0; g < `PS_DEPTH; g = g + 1)
		begin : slots
			localparam [31:0] SLOT_N = g;
			param_slot #(
				.UPD_CLASS(SLOT_N[1:0]),
				.IS_COMM(g >= `PS_COMM_FIRST)
			) u_slot (
				.clk_sys(clk_sys),
				.resetn(resetn),
				.wr_en(data_q & (id_q[3:0] == SLOT_N[3:0])),
				.wr_data(dat_q),
				.boot(boot_q),
				.nv_save(c_save),
				.nv_load(c_load),
				.init_part(c_ipart),
				.init_all(c_iall),
				.config_cmd(c_cfg),
				.motion_stopped(motion_stopped),
				.work_val(work_v[g]),
				.nv_val(nv_v[g]),
				.applied_val(app_v[g])
			);
		end
	endgenerate
	always @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			rd_work <= 32'h00000000;
			rd_applied <= 32'h00000000;
			rd_nv <= 32'h00000000;
			alarm_reset <= 1'b0;
			alarm_hist_clear <= 1'b0;
			comm_hist_clear <= 1'b0;
			position_preset <= 1'b0;
			torque_off_latch_clear <= 1'b0;
			encoder_zero_preset_command <= 1'b0;
			encoder_zero_preset_clear <= 1'b0;
			busy <= 1'b0;
			hist_sel <= 4'h0;
		end
		else
		begin
			rd_work <= work_v[rd_idx];
			rd_applied <= app_v[rd_idx];
			rd_nv <= nv_v[rd_idx];
			alarm_reset <= cmd_q & (id_q == `PS_CMD_ALARM_RST); // RULE16
			alarm_hist_clear <= cmd_q & (id_q == `PS_CMD_CLR_ALM_HIST); // RULE16
			comm_hist_clear <= cmd_q & (id_q == `PS_CMD_CLR_COM_HIST); // RULE16
			position_preset <= cmd_q & (id_q == `PS_CMD_POS_PRESET);
			torque_off_latch_clear <= cmd_q &
				(id_q == `PS_CMD_CLR_TORQUE_OFF);
			encoder_zero_preset_command <= cmd_q &
				(id_q == `PS_CMD_ZERO_PRESET);
			encoder_zero_preset_clear <= cmd_q &
				(id_q == `PS_CMD_CLR_ZERO_PRESET);
			// storage commands are spaced by the scanner, not checked here
			busy <= c_save | c_load; // RULE12
			// out-of-range selector values are dropped, old choice kept
			if (cmd_q && id_q == `PS_CMD_HIST_SEL &&
				dat_q <= `PS_HIST_SEL_MAX)
				hist_sel <= dat_q[3:0]; // RULE17
		end
	end
endmodule
`default_nettype wire

// file: tb/scanner_model.sv
// fieldbus scanner model issuing parameter and command writes
`timescale 1ns/1ps
`default_nettype none
module scanner_model (
	// write port into the block
	input wire logic clk_sys,
	output logic wr_req,
	output logic [15:0] wr_id,
	output logic [31:0] wr_data
);
	initial
	begin
		wr_req = 1'b0;
		wr_id = 16'h0000;
		wr_data = 32'h00000000;
	end
	// one strobe cycle per write; idle lines show inverted values
	task automatic put(input logic [15:0] id, input logic [31:0] d);
		@(negedge clk_sys);
		wr_req = 1'b1;
		wr_id = id;
		wr_data = d;
		@(negedge clk_sys);
		wr_req = 1'b0;
		wr_id = ~id;
		wr_data = ~d;
	endtask
endmodule
`default_nettype wire

// file: tb/ps_sva.sv
// assertions on the parameter store ports
`timescale 1ns/1ps
`default_nettype none
module ps_check (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// watched ports
	input wire logic wr_req,
	input wire logic [15:0] wr_id,
	input wire logic [31:0] wr_data,
	input wire logic alarm_reset,
	input wire logic alarm_hist_clear,
	input wire logic comm_hist_clear,
	input wire logic busy,
	input wire logic [3:0] hist_sel
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	alm_pulse_a: assert property (
		wr_req && wr_id == 16'h00c0 |-> ##2 alarm_reset)
		else $error("alarm reset missing");
	alm_hist_a: assert property (
		wr_req && wr_id == 16'h00c2 |-> ##2 alarm_hist_clear)
		else $error("alarm history clear missing");
	com_hist_a: assert property (
		wr_req && wr_id == 16'h00c4 |-> ##2 comm_hist_clear)
		else $error("comm history clear missing");
	alm_cause_a: assert property (
		alarm_reset |-> $past(wr_req, 2) && $past(wr_id, 2) == 16'h00c0)
		else $error("alarm reset without command");
	com_cause_a: assert property (
		comm_hist_clear |-> $past(wr_req, 2) && $past(wr_id, 2) == 16'h00c4)
		else $error("comm clear without command");
	nv_busy_a: assert property (
		wr_req && (wr_id == 16'h00c9 || wr_id == 16'h00c8) |-> ##2 busy)
		else $error("save or load not executed");
	sel_range_a: assert property (
		hist_sel <= 4'ha)
		else $error("history selector out of range");
	sel_take_a: assert property (
		wr_req && wr_id == 16'h00d5 && wr_data <= 32'h0000000a
		|-> ##2 hist_sel == $past(wr_data[3:0], 2))
		else $error("history selector not taken");
endmodule
bind param_store_maint ps_check ps_check_i (.clk_sys(clk_sys),
	.resetn(resetn), .wr_req(wr_req), .wr_id(wr_id), .wr_data(wr_data),
	.alarm_reset(alarm_reset), .alarm_hist_clear(alarm_hist_clear),
	.comm_hist_clear(comm_hist_clear), .busy(busy), .hist_sel(hist_sel));
`default_nettype wire

// file: tb/tb_top.sv
// testbench for the parameter store
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk_sys, resetn, wr_req, motion_stopped;
	logic [15:0] wr_id;
	logic [31:0] wr_data, rd_work, rd_applied, rd_nv;
	logic [3:0] rd_idx, hist_sel;
	logic [7:0] pulses;
	int n_errors = 0, checked = 0;
	scanner_model scanner_model_i (.clk_sys(clk_sys), .wr_req(wr_req),
		.wr_id(wr_id), .wr_data(wr_data));
	param_store_maint param_store_maint_i (.clk_sys(clk_sys),
		.resetn(resetn), .wr_req(wr_req), .wr_id(wr_id), .wr_data(wr_data),
		.motion_stopped(motion_stopped), .rd_idx(rd_idx),
		.rd_work(rd_work), .rd_applied(rd_applied), .rd_nv(rd_nv),
		.alarm_reset(pulses[7]), .alarm_hist_clear(pulses[6]),
		.comm_hist_clear(pulses[5]), .position_preset(pulses[4]),
		.torque_off_latch_clear(pulses[3]),
		.encoder_zero_preset_command(pulses[2]),
		.encoder_zero_preset_clear(pulses[1]),
		.busy(pulses[0]), .hist_sel(hist_sel));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic put(input logic [15:0] id, input logic [31:0] d);
		scanner_model_i.put(id, d);
	endtask
	// readback lags by a registered stage, so allow three edges
	task automatic rd(input logic [3:0] i);
		@(negedge clk_sys);
		rd_idx = i;
		repeat (3) @(negedge clk_sys);
	endtask
	// pulse stands for the cycle after the command is executed
	task automatic pulse(input logic [15:0] id, input logic [7:0] exp);
		put(id, 32'h0);
		@(negedge clk_sys);
		chk({24'h0, pulses}, {24'h0, exp});
		@(negedge clk_sys);
		chk({24'h0, pulses}, 32'h0);
	endtask
	task automatic power_cycle;
		resetn = 1'b0;
		repeat (6) @(negedge clk_sys);
		resetn = 1'b1;
	endtask
	task automatic t_save_boot;
		put(16'h0000, 32'h11);
		put(16'h0003, 32'h33);
		rd(4'h0);
		chk(rd_applied, 32'h11);
		rd(4'h3);
		chk(rd_applied, 32'h0);
		put(16'h00c9, 32'hffff);
		put(16'h0000, 32'h22);
		rd(4'h0);
		chk(rd_work, 32'h22);
		chk(rd_nv, 32'h11);
		power_cycle();
		rd(4'h3);
		chk(rd_applied, 32'h33);
		rd(4'h0);
		chk(rd_work, 32'h11);
		chk(rd_nv, 32'h11);
	endtask
	task automatic t_classes;
		put(16'h0001, 32'h77);
		rd(4'h1);
		chk(rd_applied, 32'h0);
		motion_stopped = 1'b1;
		rd(4'h1);
		chk(rd_applied, 32'h77);
		put(16'h0002, 32'h99);
		rd(4'h2);
		chk(rd_applied, 32'h0);
		put(16'h00c6, 32'h0);
		rd(4'h2);
		chk(rd_applied, 32'h99);
		put(16'h0000, 32'haa);
		put(16'h00c8, 32'h0);
		rd(4'h0);
		chk(rd_work, 32'h11);
		chk(rd_applied, 32'h11);
	endtask
	task automatic t_init;
		put(16'h000c, 32'h5);
		put(16'h00c7, 32'h0);
		rd(4'h0);
		chk(rd_work, 32'h0);
		rd(4'hc);
		chk(rd_work, 32'h5);
		put(16'h00ca, 32'h0);
		rd(4'hc);
		chk(rd_work, 32'h0);
	endtask
	task automatic t_cmds;
		chk({28'h0, hist_sel}, 32'h0);
		pulse(16'h00c0, 8'h80);
		pulse(16'h00c2, 8'h40);
		pulse(16'h00c4, 8'h20);
		pulse(16'h00c5, 8'h10);
		pulse(16'h00d0, 8'h08);
		pulse(16'h00d1, 8'h04);
		pulse(16'h00d2, 8'h02);
		pulse(16'h00c9, 8'h01);
		put(16'h00d5, 32'h5);
		put(16'h00d5, 32'hb);
		rd(4'h0);
		chk({28'h0, hist_sel}, 32'h5);
	endtask
	task automatic complete_run;
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial
	begin
		#400000;
		n_errors++;
		complete_run();
	end
	initial
	begin
		resetn = 1'b0;
		motion_stopped = 1'b0;
		rd_idx = 4'h0;
		power_cycle();
		// stored copy starts unknown; fill it with initial values first
		put(16'h00ca, 32'h0);
		put(16'h00c9, 32'h0);
		power_cycle();
		t_save_boot();
		t_classes();
		t_init();
		t_cmds();
		complete_run();
	end
endmodule
`default_nettype wire
